// *** core/sync_ref_pkg.sv ***
package sync_ref_pkg;

	// Clock and rate figures
	localparam int unsigned MCLK_HZ = 125000000;
	localparam int unsigned RATE_MIN_HZ = 28000;
	localparam int unsigned RATE_MAX_HZ = 103000;
	localparam int unsigned LINK_MAX_HZ = 48000;

	// Period limits in mclk cycles
	localparam logic [15:0] PERIOD_MIN = 16'(MCLK_HZ / RATE_MAX_HZ);
	localparam int unsigned PERIOD_MAX_DEF = (MCLK_HZ + RATE_MIN_HZ - 1) / RATE_MIN_HZ;
	localparam logic [15:0] LINK_PERIOD_MIN = 16'(MCLK_HZ / LINK_MAX_HZ);

	// Qualification and drift window
	localparam logic [1:0] GOOD_FRAMES = 2'h2;
	localparam logic [4:0] SYNC_LAST = 5'hF;
	localparam logic signed [3:0] DRIFT_LIMIT = 4'sh2;
	localparam logic [15:0] RATE_TOL = 16'h0002;

	// Source indices
	localparam int N_SRC = 6;
	localparam logic [2:0] SRC_WORD = 3'h0;
	localparam logic [2:0] SRC_OPT1 = 3'h1;
	localparam logic [2:0] SRC_OPT2 = 3'h2;
	localparam logic [2:0] SRC_OPT3 = 3'h3;
	localparam logic [2:0] SRC_OSYNC = 3'h4;
	localparam logic [2:0] SRC_COAX = 3'h5;
	localparam logic [2:0] SRC_LAST = 3'h5;
	localparam logic [2:0] SRC_INTERNAL = 3'h7;

	typedef enum logic [1:0] {LOCK_NONE, LOCK_VALID, LOCK_SYNC} lock_t;
	typedef lock_t [N_SRC-1:0] lock_vec_t;
	typedef enum logic [1:0] {SEL_MASTER, SEL_LOCKED, SEL_SCAN} sel_state_t;

	typedef struct packed {
		logic slave;
		logic [2:0] src;
		logic [15:0] period;
	} ref_report_t;

	function automatic logic is_optical(input logic [2:0] src);
		return (src == SRC_OPT1) || (src == SRC_OPT2) || (src == SRC_OPT3);
	endfunction

	function automatic logic src_valid(input logic [N_SRC-1:0] vec, input logic [2:0] src);
		return (src <= SRC_LAST) && vec[src];
	endfunction

endpackage

// *** core/rate_meter.sv ***
`timescale 1ns/1ns
`default_nettype none

module rate_meter #(
	parameter logic [15:0] PERIOD_MAX = 16'(sync_ref_pkg::PERIOD_MAX_DEF)
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic pin_i,
	output logic edge_o,
	output logic valid_o,
	output logic [15:0] period_o
);

	logic [2:0] sync_reg;
	logic level_reg;
	logic [15:0] cnt_reg;
	logic [1:0] good_reg;

	// Edge counts once second and third stages agree
	wire agree_w = sync_reg[1] == sync_reg[2];
	wire rise_w = agree_w && sync_reg[2] && !level_reg;
	wire in_range_w = (cnt_reg >= sync_ref_pkg::PERIOD_MIN) && (cnt_reg <= PERIOD_MAX);
	wire stale_w = cnt_reg > PERIOD_MAX;
	wire good_full_w = good_reg == sync_ref_pkg::GOOD_FRAMES;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sync_reg <= 3'h0;
			level_reg <= 1'b0;
			cnt_reg <= 16'h0;
			good_reg <= 2'h0;
			edge_o <= 1'b0;
			valid_o <= 1'b0;
			period_o <= 16'h0;
		end else if (ce_i) begin
			sync_reg <= {sync_reg[1:0], pin_i};
			if (agree_w)
				level_reg <= sync_reg[2];
			edge_o <= rise_w;
			if (rise_w)
				cnt_reg <= 16'h1;
			else if (!stale_w)
				cnt_reg <= 16'(cnt_reg + 16'h1);
			if (rise_w && in_range_w) begin
				good_reg <= good_full_w ? good_reg : 2'(good_reg + 2'h1);
				period_o <= cnt_reg;
			end else if (rise_w || stale_w)
				good_reg <= 2'h0;
			valid_o <= good_full_w && !stale_w;
		end
	end

	range_ok_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		valid_o |-> (period_o >= sync_ref_pkg::PERIOD_MIN) && (period_o <= PERIOD_MAX))
		else $error("valid input reported outside the lock range");

	timeout_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && stale_w) |=> !valid_o)
		else $error("stale input still reported valid");

endmodule

`default_nettype wire

// *** core/input_sync_monitor_clock_select.sv ***
// Contract
// - Each clock source input is reported as no signal, valid signal, or valid and synchronous.
// - The active reference input is reported together with its measured rate.
// - The block locks to any reference rate from 28 to 103 kHz, not only standard rates.
// - The word clock input accepts and tracks any frequency from 28 to 103 kHz.
// - At 88.2 or 96 kHz sample multiplex mode is entered automatically, but with an optical reference only when double_speed_i is set.
// - With a non-optical reference up to 96 kHz the optical links never run at a frame rate above 48 kHz; higher rates are multiplexed.
// - In multiplex mode each channel is spread over two link channels at a 44.1 or 48 kHz frame.
// - In multiplex mode the optical reference rate is half the coaxial (system) rate.
// - When slaved, output frames are clocked from the external reference.
// - In automatic mode the preferred input is used while valid, else inputs are scanned in turn.
// - With no valid input in automatic mode the block falls back to the crystal as master.
`timescale 1ns/1ns
`default_nettype none

module input_sync_monitor_clock_select #(
	parameter logic [15:0] PERIOD_MAX = 16'(sync_ref_pkg::PERIOD_MAX_DEF)
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [5:0] src_pin_i,
	input wire logic auto_mode_i,
	input wire logic [2:0] pref_ref_i,
	input wire logic [15:0] int_period_i,
	input wire logic double_speed_i,
	output wire sync_ref_pkg::lock_vec_t lock_o,
	output sync_ref_pkg::ref_report_t ref_report_o,
	output logic [15:0] sys_period_o,
	output logic [15:0] link_period_o,
	output logic mux_mode_o,
	output logic out_frame_o,
	output logic link_frame_o,
	output logic lane_sel_o
);

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	logic [5:0] edge_w;
	logic [5:0] valid_w;
	logic [15:0] period_w [6];

	genvar g;
	generate
		for (g = 0; g < sync_ref_pkg::N_SRC; g++) begin : meter
			rate_meter #(.PERIOD_MAX(PERIOD_MAX)) u_meter (
				.mclk_i(mclk_i),
				.sys_rst_i(sys_rst_i),
				.ce_i(ce_i),
				.pin_i(src_pin_i[g]),
				.edge_o(edge_w[g]),
				.valid_o(valid_w[g]),
				.period_o(period_w[g])
			);
		end
	endgenerate

	// Reference selection
	sync_ref_pkg::sel_state_t sel_state_reg;
	sync_ref_pkg::sel_state_t sel_state_next;
	logic [2:0] ref_sel_reg;
	logic [2:0] ref_sel_next;
	logic [2:0] scan_idx_reg;
	logic [2:0] scan_idx_next;

	wire pref_ok_w = sync_ref_pkg::src_valid(valid_w, pref_ref_i);
	wire cur_ok_w = sync_ref_pkg::src_valid(valid_w, ref_sel_reg);
	wire scan_ok_w = sync_ref_pkg::src_valid(valid_w, scan_idx_reg);
	wire any_ok_w = |valid_w;
	wire [2:0] scan_step_w = (scan_idx_reg >= sync_ref_pkg::SRC_LAST) ? 3'h0 : 3'(scan_idx_reg + 3'h1);

	always_comb begin
		sel_state_next = sel_state_reg;
		ref_sel_next = ref_sel_reg;
		scan_idx_next = scan_idx_reg;
		case (sel_state_reg)
			sync_ref_pkg::SEL_MASTER: begin
				if (auto_mode_i && any_ok_w)
					sel_state_next = sync_ref_pkg::SEL_SCAN;
			end
			sync_ref_pkg::SEL_LOCKED: begin
				if (!cur_ok_w) begin
					sel_state_next = sync_ref_pkg::SEL_SCAN;
					ref_sel_next = sync_ref_pkg::SRC_INTERNAL;
				end
			end
			sync_ref_pkg::SEL_SCAN: begin
				if (scan_ok_w) begin
					sel_state_next = sync_ref_pkg::SEL_LOCKED;
					ref_sel_next = scan_idx_reg;
				end else
					scan_idx_next = scan_step_w;
			end
			default: begin
				sel_state_next = sync_ref_pkg::SEL_MASTER;
				ref_sel_next = sync_ref_pkg::SRC_INTERNAL;
			end
		endcase
		if (auto_mode_i && pref_ok_w) begin
			sel_state_next = sync_ref_pkg::SEL_LOCKED;
			ref_sel_next = pref_ref_i;
		end
		if (!auto_mode_i || !any_ok_w) begin
			sel_state_next = sync_ref_pkg::SEL_MASTER;
			ref_sel_next = sync_ref_pkg::SRC_INTERNAL;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sel_state_reg <= sync_ref_pkg::SEL_MASTER;
			ref_sel_reg <= sync_ref_pkg::SRC_INTERNAL;
			scan_idx_reg <= 3'h0;
		end else if (ce_i) begin
			sel_state_reg <= sel_state_next;
			ref_sel_reg <= ref_sel_next;
			scan_idx_reg <= scan_idx_next;
		end
	end

	// Internal crystal frame divider
	logic [15:0] int_cnt_reg;
	logic int_tick_reg;
	wire int_wrap_w = 16'(int_cnt_reg + 16'h1) >= int_period_i;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			int_cnt_reg <= 16'h0;
			int_tick_reg <= 1'b0;
		end else if (ce_i) begin
			int_cnt_reg <= int_wrap_w ? 16'h0 : 16'(int_cnt_reg + 16'h1);
			int_tick_reg <= int_wrap_w;
		end
	end

	// Active reference and derived rates
	wire slave_w = sel_state_reg == sync_ref_pkg::SEL_LOCKED;
	wire [2:0] ref_idx_w = slave_w ? ref_sel_reg : sync_ref_pkg::SRC_WORD;
	wire ref_edge_w = slave_w ? edge_w[ref_idx_w] : int_tick_reg;
	wire [15:0] ref_period_w = slave_w ? period_w[ref_idx_w] : int_period_i;
	wire opt_ref_w = slave_w && sync_ref_pkg::is_optical(ref_sel_reg);
	wire sys_double_w = opt_ref_w ? double_speed_i : (ref_period_w < sync_ref_pkg::LINK_PERIOD_MIN);
	wire [15:0] sys_period_w = (opt_ref_w && double_speed_i) ? {1'b0, ref_period_w[15:1]} : ref_period_w;
	wire [15:0] dbl_period_w = {ref_period_w[14:0], 1'b0};
	wire [15:0] link_period_w = (opt_ref_w || !sys_double_w) ? ref_period_w : dbl_period_w;
	wire link_tick_w = ref_edge_w && (opt_ref_w || !sys_double_w || lane_sel_o);

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ref_report_o <= '{slave: 1'b0, src: sync_ref_pkg::SRC_INTERNAL, period: 16'h0};
			sys_period_o <= 16'h0;
			link_period_o <= 16'h0;
			mux_mode_o <= 1'b0;
			out_frame_o <= 1'b0;
			link_frame_o <= 1'b0;
			lane_sel_o <= 1'b0;
		end else if (ce_i) begin
			ref_report_o <= '{slave: slave_w, src: ref_sel_reg, period: ref_period_w};
			sys_period_o <= sys_period_w;
			link_period_o <= link_period_w;
			mux_mode_o <= sys_double_w;
			out_frame_o <= ref_edge_w;
			link_frame_o <= link_tick_w;
			if (!sys_double_w || opt_ref_w)
				lane_sel_o <= 1'b0;
			else if (ref_edge_w)
				lane_sel_o <= !lane_sel_o;
		end
	end

	// Drift window, counted in reference frames
	logic [4:0] win_cnt_reg;
	wire win_end_w = ref_edge_w && (win_cnt_reg == sync_ref_pkg::SYNC_LAST);

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			win_cnt_reg <= 5'h0;
		else if (ce_i && ref_edge_w)
			win_cnt_reg <= win_end_w ? 5'h0 : 5'(win_cnt_reg + 5'h1);
	end

	generate
		for (g = 0; g < sync_ref_pkg::N_SRC; g++) begin : track
			logic signed [3:0] drift_reg;
			sync_ref_pkg::lock_t lock_reg;
			wire bad_w = (drift_reg >= sync_ref_pkg::DRIFT_LIMIT) || (drift_reg <= -sync_ref_pkg::DRIFT_LIMIT);
			// Steady rate offset, too slow for the frame window to count
			wire [15:0] rate_gap_w = (period_w[g] > ref_period_w) ?
				16'(period_w[g] - ref_period_w) : 16'(ref_period_w - period_w[g]);
			wire off_rate_w = rate_gap_w > sync_ref_pkg::RATE_TOL;

			always_ff @(posedge mclk_i) begin
				if (sys_rst_i) begin
					drift_reg <= 4'sh0;
					lock_reg <= sync_ref_pkg::LOCK_NONE;
				end else if (ce_i) begin
					if (win_end_w)
						drift_reg <= 4'sh0;
					else if (!bad_w && edge_w[g] && !ref_edge_w)
						drift_reg <= drift_reg + 4'sh1;
					else if (!bad_w && !edge_w[g] && ref_edge_w)
						drift_reg <= drift_reg - 4'sh1;
					if (!valid_w[g])
						lock_reg <= sync_ref_pkg::LOCK_NONE;
					else if (bad_w || off_rate_w)
						lock_reg <= sync_ref_pkg::LOCK_VALID;
					else if (win_end_w)
						lock_reg <= sync_ref_pkg::LOCK_SYNC;
					else if (lock_reg == sync_ref_pkg::LOCK_NONE)
						lock_reg <= sync_ref_pkg::LOCK_VALID;
				end
			end

			assign lock_o[g] = lock_reg;

			lost_none_a: assert property ((ce_i && !valid_w[g]) |=> lock_o[g] == sync_ref_pkg::LOCK_NONE)
				else $error("input without signal not reported as no signal");

			drift_sync_a: assert property ((ce_i && valid_w[g] && bad_w) |=> lock_o[g] == sync_ref_pkg::LOCK_VALID)
				else $error("drifting input still reported synchronous");

			rate_sync_a: assert property ((ce_i && valid_w[g] && off_rate_w) |=>
				lock_o[g] == sync_ref_pkg::LOCK_VALID)
				else $error("input at another rate reported synchronous");
		end
	endgenerate

	sequence none_valid_s;
		(ce_i && auto_mode_i && valid_w == 6'h00)[*2];
	endsequence

	sequence pref_held_s;
		(ce_i && auto_mode_i && pref_ok_w && $stable(pref_ref_i))[*2];
	endsequence

	master_fallback_a: assert property (none_valid_s |=> !ref_report_o.slave)
		else $error("no valid input yet still slaved");

	manual_master_a: assert property ((ce_i && !auto_mode_i)[*2] |=> !ref_report_o.slave && ref_report_o.src == sync_ref_pkg::SRC_INTERNAL)
		else $error("master mode not reported");

	pref_wins_a: assert property (pref_held_s |=> ref_report_o.slave && ref_report_o.src == $past(pref_ref_i))
		else $error("valid preferred input not adopted");

	link_limit_a: assert property ((!mux_mode_o && link_period_o != 16'h0) |->
		link_period_o >= sync_ref_pkg::LINK_PERIOD_MIN)
		else $error("link frame rate above limit without multiplexing");

	half_rate_a: assert property ((mux_mode_o && ref_report_o.slave && sync_ref_pkg::is_optical(ref_report_o.src)) |-> sys_period_o == {1'b0, ref_report_o.period[15:1]})
		else $error("optical rate not half the system rate");

	frame_follow_a: assert property ((ce_i && slave_w && edge_w[ref_idx_w]) |=> out_frame_o ##0 ref_report_o.slave)
		else $error("output frame not taken from reference");

endmodule

`default_nettype wire

// *** testbench/ext_audio_source.sv ***
`timescale 1ns/1ns
`default_nettype none

// Far-side equipment: one frame clock per pin, counted on the link clock
module ext_audio_source (
	input wire logic link_clk_i,
	input wire logic [5:0] en_i,
	input wire logic [5:0] alt_sel_i,
	input wire logic [7:0] base_ticks_i,
	input wire logic [7:0] alt_ticks_i,
	output logic [5:0] pin_o
);
	logic [7:0] cnt_reg [6];
	logic [7:0] per;

	initial begin
		pin_o = 6'h00;
		for (int k = 0; k < 6; k++) begin
			cnt_reg[k] = 8'h00;
		end
	end

	// Pins on the same period and enabled together stay in phase
	always @(posedge link_clk_i) begin
		for (int k = 0; k < 6; k++) begin
			per = alt_sel_i[k] ? alt_ticks_i : base_ticks_i;
			if (en_i[k]) begin
				cnt_reg[k] <= (cnt_reg[k] >= per - 8'h01) ? 8'h00 : cnt_reg[k] + 8'h01;
				pin_o[k] <= cnt_reg[k] < (per >> 1);
			end else begin
				// Unplugged line shows no clean level
				cnt_reg[k] <= 8'h00;
				pin_o[k] <= ~pin_o[k];
			end
		end
	end
endmodule

`default_nettype wire

// *** testbench/input_sync_monitor_clock_select_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module input_sync_monitor_clock_select_tb_top;
	logic mclk_i = 1'b0;
	logic link_clk = 1'b0;
	logic sys_rst_i = 1'b1;
	logic auto_mode_i = 1'b1;
	logic [2:0] pref_ref_i = 3'h7;
	logic [15:0] int_period_i = 16'h0064;
	logic double_speed_i = 1'b0;
	logic [5:0] en = 6'h00;
	logic [5:0] src_pin;
	sync_ref_pkg::lock_vec_t lock_o;
	sync_ref_pkg::ref_report_t rep;
	logic [15:0] sys_period, link_period;
	logic mux, out_frame, link_frame;
	logic lane, lane_q;
	logic ce = 1'b1;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int no, nl, nt;

	always #4 mclk_i = ~mclk_i;
	always begin
		#63 link_clk = 1'b1;
		#62 link_clk = 1'b0;
	end

	// Base 88 ticks gives 1375 mclk cycles; pin 2 runs one tick slower
	ext_audio_source ext_audio_source_i(.link_clk_i(link_clk), .en_i(en),
		.alt_sel_i(6'h04), .base_ticks_i(8'h58), .alt_ticks_i(8'h59), .pin_o(src_pin));

	input_sync_monitor_clock_select #(.PERIOD_MAX(16'h0600)) input_sync_monitor_clock_select_i(
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .src_pin_i(src_pin),
		.auto_mode_i(auto_mode_i), .pref_ref_i(pref_ref_i), .int_period_i(int_period_i),
		.double_speed_i(double_speed_i), .lock_o(lock_o), .ref_report_o(rep),
		.sys_period_o(sys_period), .link_period_o(link_period), .mux_mode_o(mux),
		.out_frame_o(out_frame), .link_frame_o(link_frame), .lane_sel_o(lane));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic waitc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	task automatic count(input int n);
		no = 0;
		nl = 0;
		nt = 0;
		lane_q = lane;
		repeat (n) begin
			@(negedge mclk_i);
			no += int'(out_frame);
			nl += int'(link_frame);
			nt += int'(lane != lane_q);
			lane_q = lane;
		end
	endtask

	task automatic conclude;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic t_reset;
		waitc(1);
		chk(32'(rep), 32'h00070000);
		chk(32'(lock_o), 32'h00000000);
		$display("test reset done");
	endtask

	task automatic t_sync;
		@(posedge mclk_i);
		en <= 6'h27;
		pref_ref_i <= 3'h0;
		waitc(45000);
		chk(32'({rep.slave, rep.src}), 32'h8);
		chk(32'(rep.period >= 16'h055D && rep.period <= 16'h0561), 32'h1);
		chk(32'(lock_o[0]), 32'(sync_ref_pkg::LOCK_SYNC));
		chk(32'(lock_o[2]), 32'(sync_ref_pkg::LOCK_VALID));
		chk(32'(lock_o[3]), 32'(sync_ref_pkg::LOCK_NONE));
		chk(32'(mux), 32'h1);
		count(11000);
		chk(32'(no >= 7 && no <= 9), 32'h1);
		chk(32'(2 * nl >= no - 1 && 2 * nl <= no + 1), 32'h1);
		chk(32'(nt >= no - 1 && nt <= no + 1), 32'h1);
		chk(32'(link_period >= sync_ref_pkg::LINK_PERIOD_MIN), 32'h1);
		$display("test sync done");
	endtask

	task automatic t_optmux;
		@(posedge mclk_i);
		pref_ref_i <= 3'h1;
		double_speed_i <= 1'b1;
		waitc(20);
		chk(32'(rep.src), 32'h1);
		chk(32'(mux), 32'h1);
		chk(32'(sys_period), 32'(rep.period >> 1));
		$display("test optmux done");
	endtask

	task automatic t_loss;
		@(posedge mclk_i);
		en <= 6'h24;
		waitc(3000);
		chk(32'(lock_o[1]), 32'(sync_ref_pkg::LOCK_NONE));
		chk(32'(rep.slave && (rep.src == 3'h2 || rep.src == 3'h5)), 32'h1);
		$display("test loss done");
	endtask

	task automatic t_master;
		@(posedge mclk_i);
		auto_mode_i <= 1'b0;
		waitc(10);
		chk(32'({rep.slave, rep.src}), 32'h7);
		count(1000);
		chk(32'(no >= 9 && no <= 11), 32'h1);
		@(posedge mclk_i);
		auto_mode_i <= 1'b1;
		en <= 6'h00;
		waitc(3000);
		chk(32'({rep.slave, rep.src}), 32'h7);
		chk(32'(lock_o), 32'h00000000);
		$display("test master done");
	endtask

	task automatic t_freeze;
		@(negedge mclk_i iff out_frame);
		@(posedge mclk_i);
		ce <= 1'b0;
		count(300);
		chk(32'(no), 32'h0);
		chk(32'({rep.slave, rep.src}), 32'h7);
		@(posedge mclk_i);
		ce <= 1'b1;
		count(1000);
		chk(32'(no >= 9 && no <= 11), 32'h1);
		$display("test freeze done");
	endtask

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 100000) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		repeat (4) @(posedge mclk_i);
		t_reset();
		@(posedge mclk_i);
		sys_rst_i <= 1'b0;
		waitc(50);
		chk(32'({rep.slave, rep.src}), 32'h7);
		t_sync();
		t_optmux();
		t_loss();
		t_master();
		t_freeze();
		conclude();
	end
endmodule

`default_nettype wire
